// ==== logic/vjd_defines.svh ====
`ifndef VJD_DEFINES_SVH
`define VJD_DEFINES_SVH
// Clock and timing
`define VJD_CLK_MHZ          200
`define VJD_TRIP_HOLD_MS     20
`define VJD_WINDOW_MS        20
`define VJD_BLK_LEAD_MS      5
`define VJD_SAMPLES_PER_CYC  64
// Reset values of settings, angles in 0.01 deg, voltage in 0.01 percent
`define VJD_TRIP_DEF         16'h01F4
`define VJD_ALARM_DEF        16'h01F4
`define VJD_UV_DEF           16'h251C
// Angle wrap limits in 0.01 deg
`define VJD_DEG360           18'sh08CA0
`define VJD_DEG180           18'sh04650
// Log depth
`define VJD_LOG_DEPTH        12
`define VJD_LOG_PTR_LAST     4'hB
// Ratio scale, 0.01 p.u. of 1.00 = 100
`define VJD_PU_SCALE         32'h00000064
// Percent scale, 100.00 percent in 0.01 steps
`define VJD_PCT_SCALE        32'h00002710
// Nominal voltage magnitude code
`define VJD_UNOM_DEF         16'h4000
`endif

// ==== logic/vjd_pkg.sv ====
package vjd_pkg;
  // Operating modes
  typedef enum logic [2:0] {
    VJD_MODE_ON       = 3'h0,
    VJD_MODE_BLOCKED  = 3'h1,
    VJD_MODE_TEST     = 3'h2,
    VJD_MODE_TEST_BLK = 3'h3,
    VJD_MODE_OFF      = 3'h4
  } vjd_mode_t;
  // Condition and forced status
  typedef enum logic [1:0] {
    VJD_COND_NORMAL  = 2'h0,
    VJD_COND_BLOCKED = 2'h1,
    VJD_COND_TRIP    = 2'h2,
    VJD_COND_ALARM   = 2'h3
  } vjd_cond_t;
  // Monitored channel selection
  typedef enum logic [3:0] {
    VJD_SEL_ALL_PP = 4'h0,
    VJD_SEL_ANY_PP = 4'h1,
    VJD_SEL_L12    = 4'h2,
    VJD_SEL_L23    = 4'h3,
    VJD_SEL_L31    = 4'h4,
    VJD_SEL_ALL_PE = 4'h5,
    VJD_SEL_ANY_PE = 4'h6,
    VJD_SEL_L1     = 4'h7,
    VJD_SEL_L2     = 4'h8,
    VJD_SEL_L3     = 4'h9,
    VJD_SEL_U4     = 4'hA
  } vjd_sel_t;
  // Event codes, on/off pairs
  typedef enum logic [2:0] {
    VJD_EV_BLOCK_ON  = 3'h0,
    VJD_EV_BLOCK_OFF = 3'h1,
    VJD_EV_TRIP_ON   = 3'h2,
    VJD_EV_TRIP_OFF  = 3'h3,
    VJD_EV_ALARM_ON  = 3'h4,
    VJD_EV_ALARM_OFF = 3'h5,
    VJD_EV_NONE      = 3'h7
  } vjd_event_t;
endpackage

// ==== logic/vjd_chan.sv ====
`timescale 1ns/1ps
`include "vjd_defines.svh"
// One channel: angle step against the vector one window earlier
module vjd_chan
  import vjd_pkg::*;
#(
  parameter int DEPTH = `VJD_SAMPLES_PER_CYC
) (
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  // Sample stream
  input  wire logic               smp_en_in,
  input  wire logic signed [17:0] angle_in,
  input  wire logic        [15:0] mag_in,
  input  wire logic        [15:0] uv_lim_in,
  // Results
  output logic signed      [17:0] step_out,
  output logic             [15:0] step_abs_out,
  output logic                    uv_out,
  output logic             [15:0] ratio_out,
  output logic                    ready_out
);
  localparam int AW = $clog2(DEPTH);
  logic signed [17:0] hist_q [DEPTH];
  logic [AW-1:0]      wptr_q;
  logic               full_q;
  logic signed [18:0] diff;
  logic signed [18:0] wrap;
  logic [31:0]        ratio_w;

  // Wrap angle step into half a turn, giving the -180..180 range
  always_comb begin
    diff = 19'(angle_in) - 19'(hist_q[wptr_q]);
    wrap = diff;
    if (diff > 19'(`VJD_DEG180))
      wrap = diff - 19'(`VJD_DEG360);
    else if (diff < -19'(`VJD_DEG180))
      wrap = diff + 19'(`VJD_DEG360);
  end

  // Ratio in 0.01 p.u., combinational divider; its result is registered only on sample enable
  always_comb begin
    ratio_w = (uv_lim_in == 16'h0000) ? 32'h0000FFFF
            : (32'(mag_in) * `VJD_PU_SCALE) / 32'(uv_lim_in);
  end

  // Window history ring
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wptr_q <= '0;
      full_q <= 1'b0;
    end else if (smp_en_in) begin
      hist_q[wptr_q] <= angle_in;
      wptr_q         <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      if (wptr_q == AW'(DEPTH - 1))
        full_q <= 1'b1;
    end
  end

  // Registered results
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      step_out     <= '0;
      step_abs_out <= '0;
      uv_out       <= 1'b1;
      ratio_out    <= '0;
      ready_out    <= 1'b0;
    end else if (smp_en_in) begin
      step_out     <= wrap[17:0];
      step_abs_out <= wrap[18] ? 16'(-wrap) : 16'(wrap);
      uv_out       <= mag_in < uv_lim_in;
      ratio_out    <= (ratio_w > 32'h0000FFFF) ? 16'hFFFF : ratio_w[15:0];
      ready_out    <= full_q;
    end
  end
endmodule

// ==== logic/vjd_log.sv ====
`timescale 1ns/1ps
`include "vjd_defines.svh"
// Circular fault log of the latest records
module vjd_log
  import vjd_pkg::*;
#(
  parameter int DEPTH = `VJD_LOG_DEPTH,
  parameter int RW    = 86
) (
  // Clock and reset
  input  wire logic          mclk_in,
  input  wire logic          srst_in,
  // Write side
  input  wire logic          wr_in,
  input  wire logic [RW-1:0] rec_in,
  // Read side
  input  wire logic [3:0]    rd_idx_in,
  output logic      [RW-1:0] rec_out,
  output logic      [3:0]    count_out
);
  logic [RW-1:0] mem_q [DEPTH];
  logic [3:0]    wptr_q;
  logic [3:0]    slot;

  // Oldest slot gets overwritten once full
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wptr_q    <= 4'h0;
      count_out <= 4'h0;
    end else if (wr_in) begin
      mem_q[wptr_q] <= rec_in;
      wptr_q        <= (wptr_q == `VJD_LOG_PTR_LAST) ? 4'h0 : wptr_q + 4'h1;
      if (count_out != 4'(DEPTH))
        count_out <= count_out + 4'h1;
    end
  end

  // Index 0 is the newest record
  always_comb begin
    slot = (wptr_q > rd_idx_in) ? wptr_q - rd_idx_in - 4'h1
         : 4'(DEPTH) + wptr_q - rd_idx_in - 4'h1;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in)
      rec_out <= '0;
    else if (rd_idx_in < 4'(DEPTH))
      rec_out <= mem_q[slot];
    else
      rec_out <= '0;
  end
endmodule

// ==== logic/vjd_top.sv ====
`timescale 1ns/1ps
`include "vjd_defines.svh"
module vjd_top
  import vjd_pkg::*;
#(
  parameter int TRIP_HOLD_CYC = `VJD_TRIP_HOLD_MS * `VJD_CLK_MHZ * 1000,
  parameter int NCH           = 4,
  parameter int CW            = 16
) (
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  // Channel angles (0.01 deg, from complex vectors) and magnitudes
  input  wire logic               smp_en_in,
  input  wire logic signed [17:0] ch_angle_in [NCH],
  input  wire logic        [15:0] ch_mag_in   [NCH],
  input  wire logic        [NCH-1:0] ch_avail_in,
  // Program cycle and blocking pin
  input  wire logic               prog_cyc_in,
  input  wire logic               block_pin_in,
  // Settings
  input  wire logic        [15:0] trip_thr_in,
  input  wire logic        [15:0] alarm_thr_in,
  input  wire logic        [15:0] uv_pct_in,
  input  wire logic        [15:0] unom_in,
  input  wire logic               alarm_stage_in,
  input  wire vjd_sel_t           sel_in,
  input  wire vjd_mode_t          mode_in,
  input  wire logic               force_en_in,
  input  wire vjd_cond_t          force_in,
  input  wire logic        [2:0]  set_group_in,
  input  wire logic        [5:0]  ev_mask_in,
  input  wire logic        [2:0]  cnt_clr_in,
  input  wire logic        [31:0] time_in,
  input  wire logic        [3:0]  log_idx_in,
  // Outputs
  output logic                    trip_out,
  output logic                    alarm_out,
  output logic                    blocked_out,
  output vjd_cond_t               cond_out,
  output vjd_mode_t               behav_out,
  output logic                    sel_ok_out,
  output logic signed      [17:0] step_out  [NCH],
  output logic             [15:0] ratio_out [NCH],
  output logic                    ev_valid_out,
  output vjd_event_t              ev_code_out,
  output logic             [31:0] ev_time_out,
  output logic             [CW-1:0] cnt_alarm_out,
  output logic             [CW-1:0] cnt_trip_out,
  output logic             [CW-1:0] cnt_block_out,
  output logic             [85:0] log_rec_out,
  output logic             [3:0]  log_count_out
);
  localparam int HW = $clog2(TRIP_HOLD_CYC + 1);

  logic signed [17:0] step_w  [NCH];
  logic        [15:0] abs_w   [NCH];
  logic        [15:0] ratio_w [NCH];
  logic        [NCH-1:0] uv_w, rdy_w;
  logic        [15:0] uv_lim;
  logic [NCH-1:0] sel_mask;
  logic           any_mode, sel_ok;
  logic [NCH-1:0] trip_hit, alarm_hit, uvb_hit;
  logic           trip_pu, alarm_pu, uv_blk;
  logic [2:0]     blk_sync_q;
  logic           blk_pin_q, blk_q;
  logic [HW-1:0]  hold_q;
  logic           trip_q, alarm_q, blkd_q;
  logic           trip_prev_q, alarm_prev_q, blkd_prev_q;
  logic           trip_on, alarm_on, blkd_on;
  logic [1:0]     ftype;
  logic [15:0]    trip_ang, alarm_ang;
  logic [85:0]    rec_w;
  logic [5:0]     ev_raw;
  logic           mode_run, mode_blk;

  // Limit in magnitude units: unom * pct / 10000
  always_comb begin
    uv_lim = 16'((32'(unom_in) * 32'(uv_pct_in)) / `VJD_PCT_SCALE);
  end

  // Per channel engines share one threshold set
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    vjd_chan #(.DEPTH(`VJD_SAMPLES_PER_CYC)) u_chan (
      .mclk_in      (mclk_in),
      .srst_in      (srst_in),
      .smp_en_in    (smp_en_in),
      .angle_in     (ch_angle_in[i]),
      .mag_in       (ch_mag_in[i]),
      .uv_lim_in    (uv_lim),
      .step_out     (step_w[i]),
      .step_abs_out (abs_w[i]),
      .uv_out       (uv_w[i]),
      .ratio_out    (ratio_w[i]),
      .ready_out    (rdy_w[i])
    );
  end

  // Channel selection; line-line and line-earth share the first three inputs
  always_comb begin
    any_mode = 1'b0;
    case (sel_in)
      VJD_SEL_ALL_PP, VJD_SEL_ALL_PE: sel_mask = 4'h7;
      VJD_SEL_ANY_PP, VJD_SEL_ANY_PE: begin
        sel_mask = 4'h7;
        any_mode = 1'b1;
      end
      VJD_SEL_L12, VJD_SEL_L1: sel_mask = 4'h1;
      VJD_SEL_L23, VJD_SEL_L2: sel_mask = 4'h2;
      VJD_SEL_L31, VJD_SEL_L3: sel_mask = 4'h4;
      VJD_SEL_U4:              sel_mask = 4'h8;
      default:                 sel_mask = 4'h0;
    endcase
    sel_ok = (sel_mask != 4'h0) && ((sel_mask & ch_avail_in) == sel_mask);
  end

  // Pick-up: any channel for "any", every channel for "all"
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      trip_hit[i]  = sel_mask[i] && rdy_w[i] && (abs_w[i] >= trip_thr_in);
      alarm_hit[i] = sel_mask[i] && rdy_w[i] && (abs_w[i] >= alarm_thr_in);
      uvb_hit[i]   = sel_mask[i] && uv_w[i];
    end
    uv_blk   = |uvb_hit;
    trip_pu  = sel_ok && (any_mode ? |trip_hit : (trip_hit == sel_mask));
    alarm_pu = sel_ok && alarm_stage_in &&
               (any_mode ? |alarm_hit : (alarm_hit == sel_mask));
    mode_run = (mode_in == VJD_MODE_ON) || (mode_in == VJD_MODE_TEST);
    mode_blk = (mode_in == VJD_MODE_BLOCKED) || (mode_in == VJD_MODE_TEST_BLK);
  end

  // Block pin synchroniser, change accepted when stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      blk_sync_q <= 3'h0;
      blk_pin_q  <= 1'b0;
    end else begin
      blk_sync_q <= {blk_sync_q[1:0], block_pin_in};
      if (blk_sync_q[2] == blk_sync_q[1])
        blk_pin_q <= blk_sync_q[2];
    end
  end

  // Block latched only at program cycle start; upstream must lead by 5 ms
  always_ff @(posedge mclk_in) begin
    if (srst_in)
      blk_q <= 1'b0;
    else if (prog_cyc_in)
      blk_q <= blk_pin_q || mode_blk;
  end

  // Instant trip with fixed hold; no operate delay exists
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      trip_q  <= 1'b0;
      alarm_q <= 1'b0;
      blkd_q  <= 1'b0;
      hold_q  <= '0;
    end else if (!mode_run && !mode_blk) begin
      trip_q  <= 1'b0;
      alarm_q <= 1'b0;
      blkd_q  <= 1'b0;
      hold_q  <= '0;
    end else begin
      blkd_q  <= (trip_pu || alarm_pu) && (blk_q || uv_blk);
      alarm_q <= alarm_pu && !blk_q && !uv_blk;
      if (trip_pu && !blk_q && !uv_blk && !trip_q) begin
        trip_q <= 1'b1;
        hold_q <= HW'(TRIP_HOLD_CYC - 1);
      end else if (trip_q) begin
        if (hold_q == '0)
          trip_q <= 1'b0;
        else
          hold_q <= hold_q - 1'b1;
      end
    end
  end

  // Length of the running trip pulse; the fixed-depth check alone misses a short hold
  logic [HW-1:0] trip_len_q;
  always_ff @(posedge mclk_in) begin
    if (srst_in || !trip_q)
      trip_len_q <= '0;
    else
      trip_len_q <= trip_len_q + 1'b1;
  end

  trip_len_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    $fell(trip_q) && !$past(srst_in) && ($past(mode_run) || $past(mode_blk)) |->
    trip_len_q == HW'(TRIP_HOLD_CYC)) else $error("trip pulse length wrong");

  // Forced status overrides outputs, then a single condition is reported
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      trip_out    <= 1'b0;
      alarm_out   <= 1'b0;
      blocked_out <= 1'b0;
      cond_out    <= VJD_COND_NORMAL;
      behav_out   <= VJD_MODE_ON;
      sel_ok_out  <= 1'b0;
    end else begin
      behav_out  <= mode_in;
      sel_ok_out <= sel_ok;
      if (force_en_in) begin
        trip_out    <= force_in == VJD_COND_TRIP;
        alarm_out   <= force_in == VJD_COND_ALARM;
        blocked_out <= force_in == VJD_COND_BLOCKED;
        cond_out    <= force_in;
      end else begin
        trip_out    <= trip_q;
        alarm_out   <= alarm_q && !trip_q;
        blocked_out <= blkd_q;
        // Trip outranks alarm, alarm outranks blocked
        cond_out    <= trip_q ? VJD_COND_TRIP : alarm_q ? VJD_COND_ALARM :
                       blkd_q ? VJD_COND_BLOCKED : VJD_COND_NORMAL;
      end
    end
  end

  // Edge detection of the three indications
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      trip_prev_q  <= 1'b0;
      alarm_prev_q <= 1'b0;
      blkd_prev_q  <= 1'b0;
    end else begin
      trip_prev_q  <= trip_q;
      alarm_prev_q <= alarm_q;
      blkd_prev_q  <= blkd_q;
    end
  end

  assign trip_on  = trip_q && !trip_prev_q;
  assign alarm_on = alarm_q && !alarm_prev_q;
  assign blkd_on  = blkd_q && !blkd_prev_q;
  assign ev_raw   = {!alarm_q && alarm_prev_q, alarm_on, !trip_q && trip_prev_q,
                     trip_on, !blkd_q && blkd_prev_q, blkd_on} & ev_mask_in;

  // One event per cycle; lowest code wins when several coincide
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ev_valid_out <= 1'b0;
      ev_code_out  <= VJD_EV_NONE;
      ev_time_out  <= 32'h0;
    end else begin
      ev_valid_out <= |ev_raw;
      ev_time_out  <= time_in;
      ev_code_out  <= VJD_EV_NONE;
      for (int k = 5; k >= 0; k--) begin
        if (ev_raw[k])
          ev_code_out <= vjd_event_t'(3'(k));
      end
    end
  end

  // Counters; a new occurrence beats a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_alarm_out <= '0;
      cnt_trip_out  <= '0;
      cnt_block_out <= '0;
    end else begin
      if (alarm_on)
        cnt_alarm_out <= cnt_clr_in[0] ? CW'(1) : cnt_alarm_out + 1'b1;
      else if (cnt_clr_in[0])
        cnt_alarm_out <= '0;
      if (trip_on)
        cnt_trip_out <= cnt_clr_in[1] ? CW'(1) : cnt_trip_out + 1'b1;
      else if (cnt_clr_in[1])
        cnt_trip_out <= '0;
      if (blkd_on)
        cnt_block_out <= cnt_clr_in[2] ? CW'(1) : cnt_block_out + 1'b1;
      else if (cnt_clr_in[2])
        cnt_block_out <= '0;
    end
  end

  // Fault type: lowest selected channel with the largest role in pick-up
  always_comb begin
    ftype     = 2'h0;
    trip_ang  = 16'h0;
    alarm_ang = 16'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (sel_mask[i] && (abs_w[i] >= trip_ang)) begin
        ftype    = 2'(i);
        trip_ang = abs_w[i];
      end
      if (sel_mask[i] && (abs_w[i] >= alarm_ang))
        alarm_ang = abs_w[i];
    end
    // Record: time, event, type, trip angle, alarm angle, group
    rec_w = {time_in, (trip_on ? VJD_EV_TRIP_ON : alarm_on ? VJD_EV_ALARM_ON
             : VJD_EV_BLOCK_ON), ftype, trip_ang, alarm_ang, set_group_in, 14'h0};
  end

  vjd_log #(.DEPTH(`VJD_LOG_DEPTH), .RW(86)) u_log (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .wr_in     (trip_on || alarm_on || blkd_on),
    .rec_in    (rec_w),
    .rd_idx_in (log_idx_in),
    .rec_out   (log_rec_out),
    .count_out (log_count_out)
  );

  // Measured values, registered
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst_in) begin
        step_out[i]  <= '0;
        ratio_out[i] <= '0;
      end else begin
        step_out[i]  <= step_w[i];
        ratio_out[i] <= ratio_w[i];
      end
    end
  end

  // Checks
  trip_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    $rose(trip_q) |-> trip_q [*8]) else $error("trip pulse ended early");
  blk_sample_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    !prog_cyc_in |=> $stable(blk_q)) else $error("block latched off cycle start");
  blk_excl_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    blkd_q |-> !alarm_q) else $error("alarm with blocked");
  stage_only_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    !alarm_stage_in |=> !alarm_q) else $error("alarm in trip-only stage");
  lead_lag_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    smp_en_in |=> abs_w[0] == (step_w[0] < 0 ? 16'(-step_w[0]) : 16'(step_w[0])))
    else $error("absolute step mismatch");
  force_out_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    force_en_in |=> cond_out == $past(force_in)) else $error("forcing ignored");
  cnt_trip_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    trip_on && !cnt_clr_in[1] |=> cnt_trip_out == $past(cnt_trip_out) + 1'b1)
    else $error("trip counter missed");
  uv_block_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    uv_blk && !trip_q |=> !trip_q) else $error("trip under undervoltage");
endmodule

// ==== test/vjd_src.sv ====
`timescale 1ns/1ps
// Front end model: per-channel vector angle, one strobe per sample
module vjd_src #(
  parameter int PER = 1
) (
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  // Jump command
  input  wire logic               jmp_in,
  input  wire logic        [1:0]  jmp_ch_in,
  input  wire logic signed [17:0] jmp_val_in,
  input  wire logic signed [17:0] base_in,
  // Sample stream
  output logic                    smp_en_out,
  output logic signed      [17:0] angle_out [4]
);
  int cnt_q;
  // One strobe every PER cycles; a large PER models a slow source
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_q      <= 0;
      smp_en_out <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q >= PER - 1) ? 0 : cnt_q + 1;
      smp_en_out <= (cnt_q == 0);
    end
  end
  // Angle of the complex vector, still at nominal frequency
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 4; i++) begin
        angle_out[i] <= base_in + 18'(i * 1000);
      end
    end else if (jmp_in) begin
      angle_out[jmp_ch_in] <= angle_out[jmp_ch_in] + jmp_val_in;
    end
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "vjd_defines.svh"
module testbench;
  import vjd_pkg::*;
  localparam int HOLD = 100;
  logic mclk_in, srst_in, prog, pin, astg, fen, jmp, smp, sok, trip, alarm, blk, evv;
  logic [1:0] jch;
  logic signed [17:0] jval, base, ang [4], step [4];
  logic [15:0] mag [4], ratio [4], tthr, athr, ca, ct, cb;
  logic [3:0] avail, lcnt, lidx;
  logic [2:0] grp, clr;
  logic [5:0] evm;
  logic [31:0] tcnt, evt;
  logic [85:0] rec;
  vjd_sel_t sel;
  vjd_mode_t mode, behav;
  vjd_cond_t frc, cond;
  vjd_event_t evc;
  vjd_event_t evq [$];
  int n_mismatch, n_checks, seed;

  vjd_src src_u (.mclk_in(mclk_in), .srst_in(srst_in), .jmp_in(jmp), .jmp_ch_in(jch),
    .jmp_val_in(jval), .base_in(base), .smp_en_out(smp), .angle_out(ang));

  vjd_top #(.TRIP_HOLD_CYC(HOLD)) dut_u (.mclk_in(mclk_in), .srst_in(srst_in),
    .smp_en_in(smp), .ch_angle_in(ang), .ch_mag_in(mag), .ch_avail_in(avail),
    .prog_cyc_in(prog), .block_pin_in(pin), .trip_thr_in(tthr), .alarm_thr_in(athr),
    .uv_pct_in(`VJD_UV_DEF), .unom_in(16'h2710), .alarm_stage_in(astg), .sel_in(sel),
    .mode_in(mode), .force_en_in(fen), .force_in(frc), .set_group_in(grp),
    .ev_mask_in(evm), .cnt_clr_in(clr), .time_in(tcnt), .log_idx_in(lidx),
    .trip_out(trip), .alarm_out(alarm), .blocked_out(blk), .cond_out(cond),
    .behav_out(behav), .sel_ok_out(sok), .step_out(step), .ratio_out(ratio),
    .ev_valid_out(evv), .ev_code_out(evc), .ev_time_out(evt), .cnt_alarm_out(ca),
    .cnt_trip_out(ct), .cnt_block_out(cb), .log_rec_out(rec), .log_count_out(lcnt));

  // Clock, 5 ns period
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, e);
    end
  endtask

  task chk_ev(input vjd_event_t g, input vjd_event_t e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: event %0h want %0h", $time, g, e);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // Jump one channel; e = {blocked, alarm, trip} seen in the answer window
  task jump(input logic [1:0] c, input logic signed [17:0] v, input logic [2:0] e);
    logic [2:0] s;
    vjd_cond_t cs;
    int h;
    s = 3'h0;
    h = 0;
    cs = VJD_COND_NORMAL;
    @(posedge mclk_in);
    jch <= c;
    jval <= v;
    jmp <= 1'b1;
    @(posedge mclk_in);
    jmp <= 1'b0;
    repeat (12) begin
      cyc(1);
      s = s | {blk, alarm, trip};
      h = h + int'(trip === 1'b1);
      if (trip === 1'b1) cs = cond;
    end
    chk(step[c], v);
    // Bounded so a stuck trip cannot hang the run
    while (trip === 1'b1 && h < 300) begin
      cyc(1);
      h = h + int'(trip === 1'b1);
    end
    chk(s, e);
    if (e[0]) chk(h, HOLD);
    if (e[0]) chk(cs, VJD_COND_TRIP);
    cyc(80);
  endtask

  // Timestamp and program cycle start every fourth clock
  always @(posedge mclk_in) begin
    tcnt <= srst_in ? 32'h0 : tcnt + 32'h1;
    prog <= !srst_in && (tcnt[1:0] == 2'h3);
  end

  // Event watcher takes the oldest note; falling edge sees settled outputs
  always @(negedge mclk_in) begin
    if (!srst_in && evv === 1'b1) begin
      if (evq.size() == 0) chk_ev(evc, VJD_EV_NONE);
      else chk_ev(evc, evq.pop_front());
      chk(evt, tcnt - 32'h1);
    end
  end

  initial begin
    seed = 32'h5e4f2508;
    srst_in = 1'b1;
    {pin, astg, fen, jmp, jch, jval, clr, lidx} = '0;
    base = 18'($signed($random(seed)) % 9000);
    grp = 3'($random(seed));
    mag = '{default: `VJD_UV_DEF};
    avail = 4'hF;
    tthr = `VJD_TRIP_DEF;
    athr = `VJD_ALARM_DEF;
    sel = VJD_SEL_ANY_PP;
    mode = VJD_MODE_ON;
    frc = VJD_COND_NORMAL;
    evm = 6'h0C;
    cyc(8);
    chk({trip, alarm, blk, evv}, 0);
    chk(cond, VJD_COND_NORMAL);
    chk(behav, VJD_MODE_ON);
    chk(evc, VJD_EV_NONE);
    srst_in <= 1'b0;
    cyc(80);
    chk(ratio[0], 32'h64);
    chk(sok, 1);
    // Lead jump at the threshold, then the log and counters
    evq.push_back(VJD_EV_TRIP_ON);
    evq.push_back(VJD_EV_TRIP_OFF);
    jump(2'h0, 18'sd500, 3'h1);
    chk(ct, 1);
    chk(lcnt, 1);
    chk(rec[53:49], {VJD_EV_TRIP_ON, 2'h0});
    chk(rec[16:14], grp);
    // Lag jump of equal size, on events only
    evm <= 6'h04;
    evq.push_back(VJD_EV_TRIP_ON);
    jump(2'h1, -18'sd500, 3'h1);
    chk(rec[53:49], {VJD_EV_TRIP_ON, 2'h1});
    lidx <= 4'h1;
    cyc(2);
    chk(rec[53:49], {VJD_EV_TRIP_ON, 2'h0});
    lidx <= 4'h0;
    jump(2'h2, 18'sd499, 3'h0);
    @(posedge mclk_in);
    clr <= 3'h2;
    cyc(3);
    chk(ct, 0);
    clr <= 3'h0;
    // Blocking pin, set well before the jump
    evm <= 6'h03;
    evq.push_back(VJD_EV_BLOCK_ON);
    evq.push_back(VJD_EV_BLOCK_OFF);
    pin <= 1'b1;
    cyc(20);
    jump(2'h0, 18'sd800, 3'h4);
    pin <= 1'b0;
    cyc(80);
    chk(cb, 1);
    evm <= 6'h00;
    mag[0] <= 16'h2000;
    jump(2'h0, 18'sd900, 3'h4);
    mag[0] <= `VJD_UV_DEF;
    // Alarm stage with a high trip threshold
    athr <= 16'($unsigned($random(seed)) % 2000 + 500);
    tthr <= 16'h0BB8;
    astg <= 1'b1;
    evm <= 6'h30;
    evq.push_back(VJD_EV_ALARM_ON);
    evq.push_back(VJD_EV_ALARM_OFF);
    jump(2'h1, 18'sd2600, 3'h2);
    chk(ca, 1);
    astg <= 1'b0;
    jump(2'h2, 18'sd2600, 3'h0);
    tthr <= `VJD_TRIP_DEF;
    // Single pair selected and channel availability
    sel <= VJD_SEL_L12;
    jump(2'h1, 18'sd600, 3'h0);
    avail <= 4'hE;
    cyc(4);
    chk(sok, 0);
    avail <= 4'hF;
    sel <= VJD_SEL_ALL_PP;
    jump(2'h0, 18'sd600, 3'h0);
    sel <= VJD_SEL_U4;
    jump(2'h3, 18'sd600, 3'h1);
    chk(rec[50:49], 2'h3);
    mode <= VJD_MODE_OFF;
    jump(2'h3, 18'sd600, 3'h0);
    for (int m = 0; m < 5; m++) begin
      mode <= vjd_mode_t'(m);
      cyc(4);
      chk(behav, m);
    end
    fen <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      frc <= vjd_cond_t'(c);
      cyc(4);
      chk(cond, c);
    end
    chk(evq.size(), 0);
    results();
  end
endmodule
